// *** logic/pmon_pkg.sv ***
package pmon_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CUR = 2'b01,
      ST_PWR = 2'b10,
      ST_CMP = 2'b11
   } calc_state_e;

   typedef logic [15:0] word_t;

endpackage

// *** logic/pmon_regs.svh ***
`ifndef PMON_REGS_SVH
`define PMON_REGS_SVH

// register indexes; byte address is four times the index
`define PM_IDX_BUS 3'h2
`define PM_IDX_PWR 3'h3
`define PM_IDX_CUR 3'h4
`define PM_IDX_CAL 3'h5
`define PM_IDX_MASK 3'h6
`define PM_IDX_LIM 3'h7

// fields of alert_select_and_flags
`define PM_SHUNT_OVER 15
`define PM_SHUNT_UNDER 14
`define PM_BUS_OVER 13
`define PM_BUS_UNDER 12
`define PM_POWER_OVER 11
`define PM_READY_ALERT 10
`define PM_LIMIT_FLAG 4
`define PM_DONE_FLAG 3
`define PM_OVF_FLAG 2
`define PM_POLARITY 1
`define PM_LATCH 0

// writable bits of the mask register and of the calibration
`define PM_MASK_WMASK 16'hfc03
`define PM_CAL_WMASK 16'h7fff

// power-on value of every register in the bank
`define PM_RESET_VALUE 16'h0000

// current = shunt * cal >> shift; power = |current| * bus / div
// div 20000 makes one power count 25 current counts at 1.25 mV bus counts
`define PM_CUR_SHIFT 11
`define PM_POWER_DIV 32'd20000

`endif

// *** logic/power_monitor_result_alert_regs.sv ***
// Behaviour
// - bus result holds latest averaged bus level
// - bus result top bit always zero
// - power is current times bus, scaled
// - power count weighs 25 current counts
// - results update only from finished averages
// - current is shunt times calibration, signed
// - calibration read/write, low fifteen bits only
// - only highest set compare enable acts
// - shunt above limit raises alert
// - shunt below limit raises alert
// - bus above limit raises alert
// - bus below limit raises alert
// - power above limit raises alert
// - ready flag also drives alert when enabled
// - limit flag latches or follows per mode
// - ready flag sets after full calculation
// - ready clears on non-power-down config write, mask read
// - overflow flag tracks current and power steps of latest calculation
// - polarity bit picks active-low or active-high
// - latch bit holds alert until mask read
// - limit register host read/write, sixteen bits
`timescale 1ns/100ps
`include "pmon_regs.svh"

module power_monitor_result_alert_regs (
   input wire logic mclk_i, // 25 MHz clock
   input wire logic reset_i, // async reset, active high
   input wire logic [4:0] address_i, // avalon byte address
   input wire logic read_i, // avalon read
   input wire logic write_i, // avalon write
   input wire logic [31:0] writedata_i, // avalon write data
   input wire logic [3:0] byteenable_i, // avalon byte enables
   output logic [31:0] readdata_o, // avalon read data
   output logic waitrequest_o, // avalon wait request
   input wire logic sample_valid_i, // pulse: averaged samples ready
   input wire logic [15:0] shunt_sample_i, // averaged shunt level, signed
   input wire logic [15:0] bus_sample_i, // averaged bus level, unsigned
   input wire logic config_write_i, // pulse: configuration written
   input wire logic config_powerdown_i, // that write selects power-down
   output logic alert_o, // alert pin output value
   output logic alert_oe_o // alert pin drive enable
);

   pmon_pkg::calc_state_e state;
   pmon_pkg::word_t shunt_level;
   pmon_pkg::word_t bus_level;
   pmon_pkg::word_t power_result;
   pmon_pkg::word_t current_result;
   pmon_pkg::word_t scaling_calibration;
   pmon_pkg::word_t alert_threshold;
   logic [5:0] alert_enables;
   logic alert_polarity_select;
   logic alert_latch_select;
   logic limit_alert_flag;
   logic conversion_done_flag;
   logic math_overflow_flag;
   logic limit_fault;
   logic cur_ovf;
   logic signed [31:0] cur_product;
   logic signed [31:0] cur_scaled;
   logic [15:0] cur_mag;
   logic [31:0] pwr_product;
   logic [31:0] pwr_scaled;
   logic [15:0] next_current;
   logic [15:0] rd_value;
   logic sel_cal;
   logic sel_lim;
   logic sel_mask;
   logic rd_load;
   logic calc_capture;
   logic calc_cur;
   logic calc_pwr;
   logic calc_cmp;
   logic cur_too_high;
   logic cur_too_low;
   logic shunt_above;
   logic shunt_below;
   logic bus_above;
   logic bus_below;
   logic power_above;
   logic pwr_ovf;
   logic [15:0] bus_mag;
   logic [15:0] mask_word;
   logic next_waitrequest;
   logic next_limit_flag;
   logic next_done_flag;
   logic next_alert_active;
   logic wr_go;
   logic rd_go;
   logic [15:0] wr_mask;
   logic mask_read;

   // byte enables narrowed to the 16-bit register lanes
   function automatic logic [15:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[1]}}, {8{be[0]}}};
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                         input logic [15:0] lanes, input logic [15:0] wmask);
      merge = (old_v & ~(lanes & wmask)) | (new_v & lanes & wmask);
   endfunction

   // word index decode, shared by writes and the flag clear
   function automatic logic reg_hit(input logic [4:0] addr, input logic [2:0] idx);
      reg_hit = (addr[4:2] == idx);
   endfunction

   // a transfer takes effect only at the edge where waitrequest is low
   assign wr_go = write_i & ~waitrequest_o;
   assign rd_go = read_i & ~waitrequest_o;
   assign rd_load = read_i & waitrequest_o;
   assign wr_mask = lane_mask(byteenable_i);
   assign sel_cal = reg_hit(address_i, `PM_IDX_CAL);
   assign sel_lim = reg_hit(address_i, `PM_IDX_LIM);
   assign sel_mask = reg_hit(address_i, `PM_IDX_MASK);
   assign mask_read = rd_go & sel_mask;

   // sequencer phase decodes
   assign calc_capture = (state == pmon_pkg::ST_IDLE) & sample_valid_i;
   assign calc_cur = (state == pmon_pkg::ST_CUR);
   assign calc_pwr = (state == pmon_pkg::ST_PWR);
   assign calc_cmp = (state == pmon_pkg::ST_CMP);

   // one wait cycle keeps the read mux off the critical path
   assign next_waitrequest = ~((read_i | write_i) & waitrequest_o);

   // bus slave: one wait cycle, then the answer for a single cycle
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         waitrequest_o <= 1'b1;
      end else begin
         waitrequest_o <= next_waitrequest;
      end
   end

   // reserved bits 9:5 read as zero
   assign mask_word = {alert_enables, 5'h00, limit_alert_flag, conversion_done_flag,
                       math_overflow_flag, alert_polarity_select, alert_latch_select};

   always_comb begin
      rd_value = `PM_RESET_VALUE;
      case (address_i[4:2])
         `PM_IDX_BUS: rd_value = bus_level;
         `PM_IDX_PWR: rd_value = power_result;
         `PM_IDX_CUR: rd_value = current_result;
         `PM_IDX_CAL: rd_value = scaling_calibration;
         `PM_IDX_MASK: rd_value = mask_word;
         `PM_IDX_LIM: rd_value = alert_threshold;
         default: rd_value = `PM_RESET_VALUE;
      endcase
   end

   // read data loaded as waitrequest drops; unmapped reads return zero
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         readdata_o <= 32'h0000_0000;
      end else if (rd_load) begin
         readdata_o <= {16'h0000, rd_value};
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         scaling_calibration <= `PM_RESET_VALUE;
      end else if (wr_go && sel_cal) begin
         scaling_calibration <= merge(scaling_calibration, writedata_i[15:0], wr_mask, `PM_CAL_WMASK);
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         alert_threshold <= `PM_RESET_VALUE;
      end else if (wr_go && sel_lim) begin
         alert_threshold <= merge(alert_threshold, writedata_i[15:0], wr_mask, 16'hffff);
      end
   end

   // alert enables, five compares and the ready alert, live in the upper byte lane
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         alert_enables <= 6'h00;
      end else if (wr_go && sel_mask && byteenable_i[1]) begin
         alert_enables <= writedata_i[15:10];
      end
   end

   // pin mode bits; flag bits 4:2 belong to hardware and ignore writes
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         alert_polarity_select <= 1'b0;
         alert_latch_select <= 1'b0;
      end else if (wr_go && sel_mask && byteenable_i[0]) begin
         alert_polarity_select <= writedata_i[`PM_POLARITY];
         alert_latch_select <= writedata_i[`PM_LATCH];
      end
   end

   // arithmetic: shunt * cal, arithmetic shift keeps the sign
   // signed current
   assign cur_product = $signed(shunt_level) * $signed({1'b0, scaling_calibration[14:0]});
   assign cur_scaled = cur_product >>> `PM_CUR_SHIFT;
   // saturation limits of a signed sixteen-bit result
   assign cur_too_high = cur_scaled > 32'sd32767;
   assign cur_too_low = cur_scaled < -32'sd32768;
   assign cur_ovf = cur_too_high | cur_too_low;
   // saturate rather than wrap, so a suspect value keeps its sign
   assign next_current = cur_ovf ? (cur_scaled[31] ? 16'h8000 : 16'h7fff) : cur_scaled[15:0];
   assign cur_mag = current_result[15] ? 16'(-current_result) : current_result;
   assign bus_mag = {1'b0, bus_level[14:0]};
   assign pwr_product = {16'h0000, cur_mag} * {16'h0000, bus_mag};
   assign pwr_scaled = pwr_product / `PM_POWER_DIV;
   // power only overflows when the quotient needs more than sixteen bits
   assign pwr_ovf = (pwr_scaled[31:16] != 16'h0000);

   // calculation sequence: capture, current, power, compare
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state <= pmon_pkg::ST_IDLE;
      end else begin
         case (state)
            pmon_pkg::ST_IDLE: begin
               // a strobe while busy is dropped, so results stay consistent
               if (sample_valid_i) begin
                  state <= pmon_pkg::ST_CUR;
               end
            end
            pmon_pkg::ST_CUR: state <= pmon_pkg::ST_PWR;
            pmon_pkg::ST_PWR: state <= pmon_pkg::ST_CMP;
            pmon_pkg::ST_CMP: state <= pmon_pkg::ST_IDLE;
            default: state <= pmon_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         shunt_level <= `PM_RESET_VALUE;
         bus_level <= `PM_RESET_VALUE;
      end else if (calc_capture) begin
         shunt_level <= shunt_sample_i;
         bus_level <= {1'b0, bus_sample_i[14:0]};
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         current_result <= `PM_RESET_VALUE;
      end else if (calc_cur) begin
         current_result <= next_current;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         power_result <= `PM_RESET_VALUE;
      end else if (calc_pwr) begin
         power_result <= pwr_scaled[15:0];
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         math_overflow_flag <= 1'b0;
      end else if (calc_cur) begin
         // cleared by a current step that does not overflow
         math_overflow_flag <= cur_ovf;
      end else if (calc_pwr && pwr_ovf) begin
         math_overflow_flag <= 1'b1;
      end
   end

   assign shunt_above = $signed(shunt_level) > $signed(alert_threshold);
   assign shunt_below = $signed(shunt_level) < $signed(alert_threshold);
   assign bus_above = bus_level > alert_threshold;
   assign bus_below = bus_level < alert_threshold;
   assign power_above = power_result > alert_threshold;

   // limit compare, highest set enable wins
   // priority select
   always_comb begin
      limit_fault = 1'b0;
      if (alert_enables[5]) begin
         limit_fault = shunt_above;
      end else if (alert_enables[4]) begin
         limit_fault = shunt_below;
      end else if (alert_enables[3]) begin
         limit_fault = bus_above;
      end else if (alert_enables[2]) begin
         limit_fault = bus_below;
      end else if (alert_enables[1]) begin
         limit_fault = power_above;
      end
   end

   always_comb begin
      next_limit_flag = limit_alert_flag;
      // a fault found in the read cycle wins over the clear
      if (calc_cmp && (limit_fault || !alert_latch_select)) begin
         next_limit_flag = limit_fault;
      end else if (alert_latch_select && mask_read) begin
         next_limit_flag = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         limit_alert_flag <= 1'b0;
      end else begin
         limit_alert_flag <= next_limit_flag;
      end
   end

   // clear on non-power-down config write or mask read
   always_comb begin
      next_done_flag = conversion_done_flag;
      // set wins over a clear in the same cycle, so no completion is lost
      if (calc_cmp) begin
         next_done_flag = 1'b1;
      end else if (mask_read || (config_write_i && !config_powerdown_i)) begin
         next_done_flag = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         conversion_done_flag <= 1'b0;
      end else begin
         conversion_done_flag <= next_done_flag;
      end
   end

   assign next_alert_active = limit_alert_flag | (alert_enables[0] & conversion_done_flag);

   // open drain: pin value stays low, only the enable moves
   // polarity select
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         alert_o <= 1'b0;
         alert_oe_o <= 1'b0;
      end else begin
         alert_o <= 1'b0;
         alert_oe_o <= next_alert_active ^ alert_polarity_select;
      end
   end

endmodule // power_monitor_result_alert_regs

// *** sim/alert_host_side.sv ***
`timescale 1ns/100ps
module alert_host_side (
   input wire logic drive_i, // device drive value
   input wire logic drive_en_i, // device drive enable
   output logic pin_o // level the host sees
);
   assign pin_o = drive_en_i ? drive_i : 1'b1;
endmodule // alert_host_side

// *** sim/pmon_chk.sv ***
`timescale 1ns/100ps
module pmon_chk (
   input wire logic mclk_i, // clock
   input wire logic reset_i, // reset
   input wire logic [4:0] address_i, // address
   input wire logic read_i, // read
   input wire logic write_i, // write
   input wire logic [31:0] writedata_i, // write data
   input wire logic [3:0] byteenable_i, // lanes
   input wire logic [31:0] readdata_o, // read data
   input wire logic waitrequest_o, // wait
   input wire logic sample_valid_i, // sample strobe
   input wire logic [15:0] shunt_sample_i, // shunt
   input wire logic [15:0] bus_sample_i, // bus
   input wire logic config_write_i, // config write
   input wire logic config_powerdown_i, // config mode
   input wire logic alert_o, // pin value
   input wire logic alert_oe_o // pin enable
);
   logic [2:0] quiet_cnt;

   // the pin may only move a few cycles after a sample, config write or bus answer
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         quiet_cnt <= 3'h0;
      end else if (sample_valid_i || config_write_i || !waitrequest_o) begin
         quiet_cnt <= 3'h0;
      end else if (quiet_cnt != 3'h7) begin
         quiet_cnt <= quiet_cnt + 3'h1;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   sequence s_taken;
      (read_i || write_i) && waitrequest_o;
   endsequence
   sequence s_answer;
      !waitrequest_o ##1 waitrequest_o;
   endsequence

   a_wait_one_cycle: assert property (s_taken |=> s_answer)
      else $error("bus answer not after one wait cycle");
   a_idle_no_answer: assert property (!read_i && !write_i && waitrequest_o |=> waitrequest_o)
      else $error("answer without a request");
   a_bus_top_zero: assert property (s_taken ##0 read_i && address_i[4:2] == 3'h2 |=> !readdata_o[15])
      else $error("bus result top bit set");
   a_cal_top_zero: assert property (s_taken ##0 read_i && address_i[4:2] == 3'h5 |=> !readdata_o[15])
      else $error("calibration top bit set");
   a_upper_half_zero: assert property (readdata_o[31:16] == 16'h0)
      else $error("read data upper half not zero");
   a_rdata_holds: assert property ($changed(readdata_o) |-> $past(read_i && waitrequest_o))
      else $error("read data changed without a read");
   a_alert_value: assert property (alert_o == 1'b0)
      else $error("open-drain value not low");
   a_alert_quiet: assert property (quiet_cnt == 3'h7 |-> $stable(alert_oe_o))
      else $error("alert moved without a cause");
endmodule // pmon_chk

bind power_monitor_result_alert_regs pmon_chk chk (.mclk_i, .reset_i, .address_i, .read_i, .write_i,
   .writedata_i, .byteenable_i, .readdata_o, .waitrequest_o, .sample_valid_i, .shunt_sample_i,
   .bus_sample_i, .config_write_i, .config_powerdown_i, .alert_o, .alert_oe_o);

// *** sim/test_power_monitor_result_alert_regs.sv ***
`timescale 1ns/100ps
module test_power_monitor_result_alert_regs;
   logic mclk_i, reset_i, read_i, write_i, sample_valid_i, config_write_i, config_powerdown_i;
   logic waitrequest_o, alert_o, alert_oe_o, pin, act;
   logic [4:0] address_i;
   logic [3:0] byteenable_i;
   logic [31:0] writedata_i, readdata_o;
   logic [15:0] shunt_sample_i, bus_sample_i, rd, lim;
   int err_total, checks_done, cal, sh, bus, cur, pwr, k;

   power_monitor_result_alert_regs dut (.mclk_i, .reset_i, .address_i, .read_i, .write_i, .writedata_i,
      .byteenable_i, .readdata_o, .waitrequest_o, .sample_valid_i, .shunt_sample_i, .bus_sample_i,
      .config_write_i, .config_powerdown_i, .alert_o, .alert_oe_o);
   alert_host_side host (.drive_i(alert_o), .drive_en_i(alert_oe_o), .pin_o(pin));

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: register %h, want %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic exp);
      checks_done++;
      if (pin !== exp) begin
         err_total++;
         $display("unexpected at %0t: alert pin %b, want %b", $time, pin, exp);
      end
   endtask
   task automatic xfer(input bit wr, input logic [2:0] idx, input logic [15:0] wd, input logic [3:0] be);
      @(posedge mclk_i);
      read_i <= !wr;
      write_i <= wr;
      address_i <= {idx, 2'b00};
      writedata_i <= {16'h0, wd};
      byteenable_i <= be;
      do @(posedge mclk_i); while (waitrequest_o !== 1'b0);
      rd = readdata_o[15:0];
      read_i <= 1'b0;
      write_i <= 1'b0;
   endtask
   task automatic rd_chk(input logic [2:0] idx, input logic [15:0] exp);
      xfer(1'b0, idx, 16'h0, 4'hf);
      chk_reg(rd, exp);
   endtask
   task automatic wr(input logic [2:0] idx, input logic [15:0] wd);
      if (idx == 3'h5) cal = wd & 16'h7fff;
      xfer(1'b1, idx, wd, 4'hf);
   endtask
   task automatic sample(input logic [15:0] s, input logic [15:0] b);
      sh = int'($signed(s));
      bus = b & 16'h7fff;
      cur = (sh * cal) >>> 11;
      cur = cur > 32767 ? 32767 : cur < -32768 ? -32768 : cur;
      pwr = (cur < 0 ? -cur : cur) * bus / 20000;
      @(posedge mclk_i);
      sample_valid_i <= 1'b1;
      shunt_sample_i <= s;
      bus_sample_i <= b;
      @(posedge mclk_i);
      sample_valid_i <= 1'b0;
      repeat (7) @(posedge mclk_i);
   endtask
   task automatic cfg(input logic pd, input logic exp);
      @(posedge mclk_i);
      config_write_i <= 1'b1;
      config_powerdown_i <= pd;
      @(posedge mclk_i);
      config_write_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      chk_pin(exp);
   endtask

   initial begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   // generous bound: the whole sequence needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge mclk_i);
      err_total++;
      $display("unexpected at %0t: run timed out", $time);
      give_verdict;
   end

   initial begin
      {reset_i, read_i, write_i, sample_valid_i, config_write_i, config_powerdown_i} = 6'h20;
      address_i = 5'h0;
      writedata_i = 32'h0;
      byteenable_i = 4'hf;
      shunt_sample_i = 16'h0;
      bus_sample_i = 16'h0;
      {err_total, checks_done, cal} = '0;
      void'($urandom(32'h2d1f));
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      for (int i = 0; i < 8; i++) rd_chk(i[2:0], 16'h0);
      chk_pin(1'b1);
      wr(3'h2, 16'hffff);
      rd_chk(3'h2, 16'h0);
      wr(3'h5, 16'hffff);
      rd_chk(3'h5, 16'h7fff);
      xfer(1'b1, 3'h7, 16'h1234, 4'h1);
      rd_chk(3'h7, 16'h0034);
      // shunt-over outranks bus-over, which alone would fire here
      wr(3'h6, 16'ha000);
      sample(16'h8000, 16'd100);
      chk_pin(1'b1);
      rd_chk(3'h4, 16'h8000);
      rd_chk(3'h3, pwr[15:0]);
      rd_chk(3'h6, 16'ha00c);
      for (int i = 0; i < 10; i++) begin
         k = 11 + i % 5;
         wr(3'h5, 16'($urandom % 1024));
         lim = 16'($urandom);
         wr(3'h7, lim);
         wr(3'h6, 16'h1 << k);
         sample(16'($urandom), 16'($urandom));
         act = k == 15 ? sh > int'($signed(lim)) : k == 14 ? sh < int'($signed(lim)) :
            k == 13 ? bus > lim : k == 12 ? bus < lim : pwr > lim;
         chk_pin(!act);
         rd_chk(3'h4, cur[15:0]);
         rd_chk(3'h3, pwr[15:0]);
         rd_chk(3'h2, bus[15:0]);
         rd_chk(3'h6, (16'h1 << k) | {11'h0, act, 4'h8});
      end
      wr(3'h7, 16'd100);
      wr(3'h6, 16'h2001);
      sample(16'h0, 16'd200);
      sample(16'h0, 16'd50);
      chk_pin(1'b0);
      rd_chk(3'h6, 16'h2019);
      repeat (3) @(posedge mclk_i);
      chk_pin(1'b1);
      wr(3'h6, 16'h2002);
      sample(16'h0, 16'd200);
      chk_pin(1'b1);
      sample(16'h0, 16'd50);
      chk_pin(1'b0);
      wr(3'h6, 16'h0400);
      sample(16'h0, 16'h0);
      chk_pin(1'b0);
      cfg(1'b1, 1'b0);
      cfg(1'b0, 1'b1);
      give_verdict;
   end
endmodule // test_power_monitor_result_alert_regs
